// >>> design/aux_reply_defs.vh
// constants for the sub-command response packer
`ifndef AUX_REPLY_DEFS_VH
`define AUX_REPLY_DEFS_VH

// ============================================================
// register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_MON_SEL   8'h04
`define ADDR_STATUS    8'h08
`define ADDR_ECHO      8'h0c
`define ADDR_IRQ_STAT  8'h10
`define ADDR_IRQ_EN    8'h14
`define ADDR_IRQ_CLR   8'h18

// ============================================================
// field positions
`define CTRL_MODE32    0
`define SEL4_LSB       0
`define SEL5_LSB       8
`define SEL6_LSB       16
`define FLG_REJECT     7
`define FLG_FAIL       6
`define FLG_WARN       5
`define FLG_BUSY       4
`define IRQ_REJECT     0
`define IRQ_FAIL       1
`define IRQ_WARN       2
`define IRQ_PROT       3
`define IRQ_DONE       4

// ============================================================
// reset values and codes
`define CTRL_RST       1'b1
`define MON_SEL_RST    8'h00
`define IRQ_EN_RST     5'h00
`define CODE_NORMAL    4'h0
`define MON_SEL_OFF    8'h00

// ============================================================
// frame layout and interrupt width
`define RESP_FIRST     8'h10
`define RESP_BYTES     5'h10
`define RESP_LAST_IDX  4'hf
`define IRQ_W          5

`endif

// >>> design/monitor_word_pick.v
// one monitor-select channel: type code chooses a monitor word
`timescale 1ns/1ns
module monitor_word_pick #(
    parameter NUM_MON = 16
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] type_code,
    input wire [32*NUM_MON-1:0] mon_data,
    output reg [31:0] word_r
);

// ============================================================
// selection
// codes beyond the supplied set read as zero rather than alias
reg [31:0] word_nxt;
integer i;

always @* begin
    word_nxt = 32'h0000_0000;
    for (i = 1; i < NUM_MON; i = i + 1) begin
        if (type_code == i[7:0]) begin
            word_nxt = mon_data[32*i +: 32];
        end
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        word_r <= 32'h0000_0000;
    end else begin
        word_r <= word_nxt;
    end
end

endmodule // monitor_word_pick

// >>> design/sticky_events.v
// sticky event bits with write-to-clear, set wins over clear
`timescale 1ns/1ns
module sticky_events #(
    parameter W = 5
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [W-1:0] set_evt,
    input wire [W-1:0] clr_mask,
    output reg [W-1:0] stat_r
);

// ============================================================
// status bits
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        stat_r <= {W{1'b0}};
    end else begin
        stat_r <= (stat_r & ~clr_mask) | set_evt;
    end
end

endmodule // sticky_events

// >>> design/aux_reply_packer.v
// builds bytes 16..31 of the 32-byte response frame
// Operation
// - bytes 16-31: flags/code, type, index, then three data words.
// - every multi-byte field goes out least significant byte first.
// - reject flag set on receive error, before any execution.
// - execution-failure flag set on error while processing accepted command.
// - warning flag set on problem found after processing completes.
// - in-progress flag held at one throughout processing.
// - code, type and index echoed back unchanged.
// - with normal code, word one carries monitor select four quantity.
// - word one is zero whenever monitor select four is zero; the code sends the command result there for non-normal codes.
// - word two carries monitor select five quantity, zero when zero.
// - word three carries monitor select six quantity, zero when zero.
// - each monitor select is an 8-bit monitor type code.
// - block sent toward host only in 32-byte frame format.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "aux_reply_defs.vh"
module aux_reply_packer #(
    parameter NUM_MON = 16
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire cmd_valid,
    input wire cmd_marker,
    input wire [3:0] cmd_code,
    input wire [7:0] cmd_type,
    input wire [15:0] cmd_index,
    input wire cmd_rx_err,
    output reg exec_start_r,
    input wire exec_done,
    input wire exec_err,
    input wire exec_warn,
    input wire [31:0] exec_result,
    input wire [32*NUM_MON-1:0] mon_data,
    input wire resp_req,
    output reg [7:0] resp_byte_r,
    output reg [7:0] resp_pos_r,
    output reg resp_valid_r,
    output reg resp_last_r,
    output reg prot_err_r,
    output wire irq
);

// ============================================================
// registers
reg mode32_r;
reg [7:0] mon_sel4_r;
reg [7:0] mon_sel5_r;
reg [7:0] mon_sel6_r;
reg [`IRQ_W-1:0] irq_en_r;
reg reject_r;
reg fail_r;
reg warn_r;
reg busy_r;
reg [3:0] code_echo_r;
reg [7:0] type_echo_r;
reg [15:0] index_echo_r;
reg [31:0] result_r;
wire [31:0] mon_word4;
wire [31:0] mon_word5;
wire [31:0] mon_word6;
wire [`IRQ_W-1:0] irq_stat;
reg [`IRQ_W-1:0] irq_clr;
reg [`IRQ_W-1:0] irq_set;

// ============================================================
// monitor channels
monitor_word_pick #(.NUM_MON(NUM_MON)) pick4 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .type_code(mon_sel4_r),
    .mon_data(mon_data),
    .word_r(mon_word4)
);

monitor_word_pick #(.NUM_MON(NUM_MON)) pick5 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .type_code(mon_sel5_r),
    .mon_data(mon_data),
    .word_r(mon_word5)
);

monitor_word_pick #(.NUM_MON(NUM_MON)) pick6 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .type_code(mon_sel6_r),
    .mon_data(mon_data),
    .word_r(mon_word6)
);

// ============================================================
// command acceptance and flags
// a new command while busy is taken and restarts tracking; the
// executor is expected to abandon the old one on exec_start
wire cmd_take = cmd_valid & mode32_r & cmd_marker;
wire marker_bad = cmd_valid & mode32_r & ~cmd_marker;
wire finish = busy_r & exec_done;
wire warn_evt = ~busy_r & exec_warn & ~reject_r;

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        reject_r <= 1'b0;
        fail_r <= 1'b0;
        warn_r <= 1'b0;
        busy_r <= 1'b0;
        code_echo_r <= 4'h0;
        type_echo_r <= 8'h00;
        index_echo_r <= 16'h0000;
        result_r <= 32'h0000_0000;
        exec_start_r <= 1'b0;
        prot_err_r <= 1'b0;
    end else begin
        exec_start_r <= 1'b0;
        prot_err_r <= marker_bad;
        if (cmd_take) begin
            code_echo_r <= cmd_code;
            type_echo_r <= cmd_type;
            index_echo_r <= cmd_index;
            fail_r <= 1'b0;
            warn_r <= 1'b0;
            result_r <= 32'h0000_0000;
            if (cmd_rx_err) begin
                reject_r <= 1'b1;
                busy_r <= 1'b0;
            end else begin
                reject_r <= 1'b0;
                busy_r <= 1'b1;
                exec_start_r <= 1'b1;
            end
        end else begin
            if (finish) begin
                busy_r <= 1'b0;
                result_r <= exec_result;
                if (exec_err) begin
                    fail_r <= 1'b1;
                end
            end
            if (warn_evt) begin
                warn_r <= 1'b1;
            end
        end
    end
end

// ============================================================
// interrupt events
// a command taken in the same cycle masks done, fail and warn events
always @* begin
    irq_set = {`IRQ_W{1'b0}};
    irq_set[`IRQ_REJECT] = cmd_take & cmd_rx_err;
    irq_set[`IRQ_FAIL] = ~cmd_take & finish & exec_err;
    irq_set[`IRQ_WARN] = ~cmd_take & warn_evt;
    irq_set[`IRQ_PROT] = marker_bad;
    irq_set[`IRQ_DONE] = ~cmd_take & finish;
end

sticky_events #(.W(`IRQ_W)) events (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set_evt(irq_set),
    .clr_mask(irq_clr),
    .stat_r(irq_stat)
);

// level output, drops as soon as software clears or disables the bit
assign irq = |(irq_stat & irq_en_r);

// ============================================================
// response image
wire [7:0] flag_byte = {reject_r, fail_r, warn_r, busy_r, code_echo_r};
// word one: monitor only for the normal code, else command result
wire [31:0] word1 = (code_echo_r == `CODE_NORMAL) ?
    mon_word4 : result_r;
// little endian image: byte 16 sits in bits 7:0
wire [127:0] image = {mon_word6, mon_word5, word1,
    index_echo_r, type_echo_r, flag_byte};

// ============================================================
// serializer
// a request during a burst is dropped, not queued
localparam ST_IDLE = 2'b01;
localparam ST_SEND = 2'b10;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [127:0] shift_r;
reg [3:0] cnt_r;

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (resp_req & mode32_r) begin
                state_nxt = ST_SEND;
            end
        end
        ST_SEND: begin
            if (cnt_r == `RESP_LAST_IDX) begin
                state_nxt = ST_IDLE;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        state_r <= ST_IDLE;
        shift_r <= 128'h0;
        cnt_r <= 4'h0;
        resp_byte_r <= 8'h00;
        resp_pos_r <= 8'h00;
        resp_valid_r <= 1'b0;
        resp_last_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        resp_valid_r <= 1'b0;
        resp_last_r <= 1'b0;
        if (state_r == ST_IDLE) begin
            cnt_r <= 4'h0;
            if (resp_req & mode32_r) begin
                shift_r <= image;
            end
        end else begin
            // lowest byte leaves first, so each field goes lsb first
            resp_byte_r <= shift_r[7:0];
            resp_pos_r <= `RESP_FIRST + {4'h0, cnt_r};
            resp_valid_r <= 1'b1;
            resp_last_r <= (cnt_r == `RESP_LAST_IDX);
            shift_r <= {8'h00, shift_r[127:8]};
            cnt_r <= cnt_r + 4'h1;
        end
    end
end

// ============================================================
// register writes
// read-only and unmapped addresses simply fall through
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        mode32_r <= `CTRL_RST;
        mon_sel4_r <= `MON_SEL_RST;
        mon_sel5_r <= `MON_SEL_RST;
        mon_sel6_r <= `MON_SEL_RST;
        irq_en_r <= `IRQ_EN_RST;
    end else if (reg_wr) begin
        if (reg_addr == `ADDR_CTRL) begin
            mode32_r <= reg_wdata[`CTRL_MODE32];
        end else if (reg_addr == `ADDR_MON_SEL) begin
            mon_sel4_r <= reg_wdata[`SEL4_LSB +: 8];
            mon_sel5_r <= reg_wdata[`SEL5_LSB +: 8];
            mon_sel6_r <= reg_wdata[`SEL6_LSB +: 8];
        end else if (reg_addr == `ADDR_IRQ_EN) begin
            irq_en_r <= reg_wdata[`IRQ_W-1:0];
        end
    end
end

always @* begin
    irq_clr = {`IRQ_W{1'b0}};
    if (reg_wr && reg_addr == `ADDR_IRQ_CLR) begin
        irq_clr = reg_wdata[`IRQ_W-1:0];
    end
end

// ============================================================
// register reads, data one cycle after the strobe
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        if (reg_addr == `ADDR_CTRL) begin
            reg_rdata <= {31'h0, mode32_r};
        end else if (reg_addr == `ADDR_MON_SEL) begin
            reg_rdata <= {8'h00, mon_sel6_r, mon_sel5_r, mon_sel4_r};
        end else if (reg_addr == `ADDR_STATUS) begin
            reg_rdata <= {24'h0, flag_byte};
        end else if (reg_addr == `ADDR_ECHO) begin
            reg_rdata <= {8'h00, index_echo_r, type_echo_r};
        end else if (reg_addr == `ADDR_IRQ_STAT) begin
            reg_rdata <= {27'h0, irq_stat};
        end else if (reg_addr == `ADDR_IRQ_EN) begin
            reg_rdata <= {27'h0, irq_en_r};
        end else begin
            // unmapped and write-only addresses read zero
            reg_rdata <= 32'h0000_0000;
        end
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

endmodule // aux_reply_packer

// >>> testbench/aux_reply_packer_asserts.sv
// port checker for the sub-command response packer
`timescale 1ns/1ns
// ============================================================
// checker
module aux_reply_packer_chk (
    input wire ref_clk,
    input wire rst_b,
    input wire cmd_valid,
    input wire cmd_marker,
    input wire cmd_rx_err,
    input wire exec_start_r,
    input wire resp_req,
    input wire [7:0] resp_pos_r,
    input wire resp_valid_r,
    input wire resp_last_r,
    input wire prot_err_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    first_byte_a: assert property ($rose(resp_valid_r) |->
        resp_pos_r == 8'h10 && $past(resp_req, 2)) else $error("bad start");
    byte_step_a: assert property (resp_valid_r && !resp_last_r |=>
        resp_valid_r && resp_pos_r == $past(resp_pos_r) + 8'h01)
        else $error("byte order broken");
    last_pos_a: assert property (resp_last_r |->
        resp_valid_r && resp_pos_r == 8'h1f) else $error("bad last byte");
    burst_end_a: assert property (resp_last_r |=> !resp_valid_r)
        else $error("burst too long");
    pos_range_a: assert property (resp_valid_r |->
        resp_pos_r >= 8'h10 && resp_pos_r <= 8'h1f) else $error("bad pos");
    start_cause_a: assert property (exec_start_r |->
        $past(cmd_valid && cmd_marker && !cmd_rx_err))
        else $error("start without clean command");
    reject_stop_a: assert property (cmd_valid && cmd_rx_err |=>
        !exec_start_r) else $error("rejected command started");
    prot_cause_a: assert property (prot_err_r |->
        $past(cmd_valid && !cmd_marker)) else $error("spurious prot error");
    cover property (resp_last_r);
    cover property (prot_err_r);
    cover property (exec_start_r);
endmodule // aux_reply_packer_chk

bind aux_reply_packer aux_reply_packer_chk i_chk (.ref_clk, .rst_b,
    .cmd_valid, .cmd_marker, .cmd_rx_err, .exec_start_r, .resp_req,
    .resp_pos_r, .resp_valid_r, .resp_last_r, .prot_err_r);

// >>> testbench/frame_host.sv
// host side model: requests the response block and gathers it
`timescale 1ns/1ns
// ============================================================
// collector
module frame_host (
    input wire ref_clk,
    input wire go,
    input wire [7:0] resp_byte_r,
    input wire [7:0] resp_pos_r,
    input wire resp_valid_r,
    input wire resp_last_r,
    output reg resp_req,
    output reg [127:0] img,
    output reg got
);
    initial begin
        resp_req = 1'b0;
        img = 128'h0;
        got = 1'b0;
    end
    // one request pulse per go; stale image bytes are all overwritten
    always @(posedge ref_clk) begin
        resp_req <= go;
        if (go) begin
            got <= 1'b0;
        end
        if (resp_valid_r) begin
            img[8*(resp_pos_r-8'h10)+:8] <= resp_byte_r;
        end
        if (resp_last_r) begin
            got <= 1'b1;
        end
    end
endmodule // frame_host

// >>> testbench/aux_reply_packer_bench.sv
// self-checking bench for the sub-command response packer
`timescale 1ns/1ns
`include "aux_reply_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
// ============================================================
// bench
module aux_reply_packer_bench;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg cmd_valid = 1'b0;
    reg cmd_marker = 1'b0;
    reg [3:0] cmd_code = 4'h0;
    reg [7:0] cmd_type = 8'h00;
    reg [15:0] cmd_index = 16'h0;
    reg cmd_rx_err = 1'b0;
    reg exec_done = 1'b0;
    reg exec_err = 1'b0;
    reg exec_warn = 1'b0;
    reg [31:0] exec_result = 32'h0;
    reg [511:0] mon_data = 512'h0;
    reg go = 1'b0;
    wire [31:0] reg_rdata;
    wire exec_start_r, resp_req, resp_valid_r, resp_last_r, prot_err_r, irq;
    wire [7:0] resp_byte_r, resp_pos_r;
    wire [127:0] img;
    wire got;
    int miscompares = 0;
    int checks_done = 0;
    aux_reply_packer i_dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_marker, .cmd_code,
        .cmd_type, .cmd_index, .cmd_rx_err, .exec_start_r, .exec_done,
        .exec_err, .exec_warn, .exec_result, .mon_data, .resp_req,
        .resp_byte_r, .resp_pos_r, .resp_valid_r, .resp_last_r,
        .prot_err_r, .irq);
    frame_host i_host (.ref_clk, .go, .resp_byte_r, .resp_pos_r,
        .resp_valid_r, .resp_last_r, .resp_req, .img, .got);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // distinct bytes in every monitor word expose byte swaps
    function [31:0] m(input integer k);
        m = 32'h04030201 + k * 32'h10101010;
    endfunction
    task complete_run;
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        `CHK("rdata", e, reg_rdata)
        @(posedge ref_clk);
    endtask
    task cmd(input [3:0] c, input [7:0] t, input [15:0] x, input er, mk);
        cmd_code <= c;
        cmd_type <= t;
        cmd_index <= x;
        cmd_rx_err <= er;
        cmd_marker <= mk;
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
        `CHK("start", !er && mk, exec_start_r)
        `CHK("prot", !mk, prot_err_r)
        @(posedge ref_clk);
    endtask
    task done(input er, input [31:0] r);
        exec_result <= r;
        exec_err <= er;
        exec_done <= 1'b1;
        @(posedge ref_clk);
        exec_done <= 1'b0;
        @(posedge ref_clk);
    endtask
    task frame(input [127:0] e, input integer nb);
        integer i;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        // let the model's clear of the done flag land before polling
        @(posedge ref_clk);
        i = 0;
        while (got !== 1'b1 && i < 40) begin
            @(posedge ref_clk);
            i++;
        end
        if (i == 40) begin
            miscompares++;
            complete_run;
        end
        for (i = 0; i < nb; i++) begin
            `CHK("byte", e[8*i+:8], img[8*i+:8])
        end
    endtask
    initial begin
        for (int k = 0; k < 16; k++) begin
            mon_data[32*k+:32] = m(k);
        end
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(`ADDR_CTRL, 32'h1);
        rd(`ADDR_MON_SEL, 32'h0);
        rd(8'h1c, 32'h0);
        wr(`ADDR_MON_SEL, 32'h0201);
        rd(`ADDR_MON_SEL, 32'h0201);
        cmd(4'h0, 8'h5a, 16'hbe17, 1'b0, 1'b1);
        frame({32'h0, m(2), m(1), 16'hbe17, 8'h5a, 8'h10}, 16);
        done(1'b0, 32'h5eed0001);
        frame({32'h0, m(2), m(1), 16'hbe17, 8'h5a, 8'h00}, 16);
        wr(`ADDR_MON_SEL, 32'h030000);
        frame({m(3), 64'h0, 16'hbe17, 8'h5a, 8'h00}, 16);
        cmd(4'h2, 8'h33, 16'h0102, 1'b0, 1'b1);
        done(1'b1, 32'hcafe0123);
        frame({m(3), 32'h0, 32'hcafe0123, 24'h010233, 8'h42}, 16);
        exec_warn <= 1'b1;
        @(posedge ref_clk);
        exec_warn <= 1'b0;
        frame({120'h0, 8'h62}, 1);
        cmd(4'ha, 8'h44, 16'h5566, 1'b1, 1'b1);
        frame({96'h0, 16'h5566, 8'h44, 8'h8a}, 4);
        rd(`ADDR_STATUS, 32'h8a);
        rd(`ADDR_ECHO, 32'h556644);
        rd(`ADDR_IRQ_STAT, 32'h17);
        wr(`ADDR_IRQ_CLR, 32'h1f);
        rd(`ADDR_IRQ_STAT, 32'h0);
        cmd(4'h0, 8'h00, 16'h0, 1'b0, 1'b0);
        `CHK("irq", 1'b0, irq)
        rd(`ADDR_IRQ_STAT, 32'h08);
        wr(`ADDR_IRQ_EN, 32'h08);
        rd(`ADDR_IRQ_EN, 32'h08);
        `CHK("irq", 1'b1, irq)
        wr(`ADDR_IRQ_CLR, 32'h08);
        rd(`ADDR_IRQ_CLR, 32'h0);
        `CHK("irq", 1'b0, irq)
        // with the short format selected no block may leave
        wr(`ADDR_CTRL, 32'h0);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (20) @(posedge ref_clk);
        `CHK("ignored", 1'b0, got)
        complete_run;
    end
endmodule // aux_reply_packer_bench
